// ---- adrb_bank.sv ----
`timescale 1ns/1ns
`include "adrb_regs.svh"
module adrb_bank
  import adrb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // holding-register port
  input  wire adrb_req_t   i_req,
  output logic [15:0]      o_rdata,
  output logic             o_exception,
  // status inputs from firmware-side logic
  input  wire adrb_drive_t i_drive,
  input  wire logic [15:0] i_analog_ua,
  input  wire logic [15:0] i_analog_raw,
  input  wire logic [6:0]  i_position_pct,
  input  wire logic        i_calibrated,
  input  wire logic        i_span_short,
  input  wire logic        i_comm_lost,
  input  wire logic        i_wd_reset,
  input  wire logic        i_nv_fail,
  input  wire logic        i_nv_recovered,
  input  wire logic        i_speed_meas_bad,
  input  wire logic        i_shut_moving,
  input  wire logic        i_loop_active,
  input  wire logic        i_start_done,
  input  wire logic        i_minute_tick,
  // configuration held elsewhere
  input  wire logic        i_src_local,
  input  wire logic        i_onoff,
  input  wire logic [6:0]  i_default_pct,
  // outputs to the position loop
  output logic [6:0]       o_applied_pct,
  output logic             o_actuate_en,
  output logic             o_recal_start,
  output logic [15:0]      o_cal_lo,
  output logic [15:0]      o_cal_hi,
  output logic             o_fault_ack
);

  // ========================================================================
  // functions
  function automatic logic [6:0] resolve_onoff(input logic [15:0] v);
    resolve_onoff = (v >= `ADRB_ONOFF_SPLIT) ? 7'd100 : 7'd0;
  endfunction : resolve_onoff

  function automatic logic is_one(input logic [15:0] v);
    is_one = (v == 16'h0001);
  endfunction : is_one

  // ========================================================================
  // storage
  logic [15:0] position_demand;
  logic [15:0] fault_reset_request;
  logic [15:0] recalibrate_request;
  logic [15:0] fault_flag_word;
  logic [31:0] actuation_counter;
  logic [31:0] powered_time_counter;
  logic [15:0] time_hi_snap;
  logic [15:0] act_hi_snap;
  logic [24:0] stall_cnt;
  logic        wd_seen;
  adrb_rst_t   rst_state;
  adrb_seq_t   seq_state;
  logic [15:0] next_flags;

  // raw conditions behind the flags, the fault summary and the write decodes
  logic overspeed;
  logic coast;
  logic alow;
  logic ain_ok;
  logic fault_any;
  logic wr_demand;
  logic wr_reset;
  logic demand_ok;
  assign overspeed = i_drive.speed_rpm > `ADRB_OVSPD_RPM;
  assign coast     = i_drive.speed_rpm > `ADRB_COAST_RPM;
  assign alow      = i_analog_ua < `ADRB_ALOW_UA;
  assign ain_ok    = !alow && (i_analog_ua <= `ADRB_AHIGH_UA);
  // faults are the latching upper bits plus the comms timeout
  assign fault_any = |(fault_flag_word & (`ADRB_LATCH_MASK | 16'h4800
                                          | 16'h1500));
  assign demand_ok = i_req.wdata <= `ADRB_FULL_PCT;
  assign wr_demand = i_req.wr && i_req.addr == `ADRB_OFS_DEMAND && demand_ok;
  assign wr_reset  = i_req.wr && i_req.addr == `ADRB_OFS_FRESET;

  // ========================================================================
  // demand register, out-of-range values are refused
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      position_demand <= 16'h0000;
    end else if (wr_demand) begin
      position_demand <= i_req.wdata;
    end
  end

  // ========================================================================
  // fault reset sequencer: take, acknowledge, clear the register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rst_state           <= ADRB_RST_IDLE;
      fault_reset_request <= 16'h0000;
    end else begin
      unique case (rst_state)
        ADRB_RST_IDLE: begin
          // a request with no fault present is dropped
          if (wr_reset && is_one(i_req.wdata) && fault_any) begin
            fault_reset_request <= 16'h0001;
            rst_state           <= ADRB_RST_ACK;
          end
        end
        ADRB_RST_ACK: begin
          fault_reset_request <= 16'h0000;
          rst_state           <= ADRB_RST_DONE;
        end
        ADRB_RST_DONE: begin
          rst_state <= ADRB_RST_IDLE;
        end
        default: rst_state <= ADRB_RST_IDLE;
      endcase
    end
  end
  // combinational so the port sees the ack in the ACK cycle itself
  assign o_fault_ack = (rst_state == ADRB_RST_ACK);

  // ========================================================================
  // recalibration: register write, or 100 then 0 during start delay
  // other demands between 100 and 0 leave the sequence armed
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      seq_state           <= ADRB_SEQ_WAIT;
      recalibrate_request <= 16'h0000;
      o_recal_start       <= 1'b0;
    end else begin
      o_recal_start <= 1'b0;
      if (i_req.wr && i_req.addr == `ADRB_OFS_RECAL
          && is_one(i_req.wdata)) begin
        recalibrate_request <= 16'h0001;
        o_recal_start       <= 1'b1;
      end else if (recalibrate_request != 16'h0000) begin
        recalibrate_request <= 16'h0000;
      end
      unique case (seq_state)
        ADRB_SEQ_WAIT: begin
          if (fault_flag_word[`ADRB_BIT_STARTDLY] && wr_demand
              && i_req.wdata == `ADRB_FULL_PCT) begin
            seq_state <= ADRB_SEQ_FULL;
          end
        end
        ADRB_SEQ_FULL: begin
          if (!fault_flag_word[`ADRB_BIT_STARTDLY]) begin
            seq_state <= ADRB_SEQ_WAIT;
          end else if (wr_demand && i_req.wdata == 16'h0000) begin
            o_recal_start <= 1'b1;
            seq_state     <= ADRB_SEQ_HIT;
          end
        end
        ADRB_SEQ_HIT: seq_state <= ADRB_SEQ_WAIT;
        default:      seq_state <= ADRB_SEQ_WAIT;
      endcase
    end
  end

  // ========================================================================
  // analog calibration points, defaults until a write stores a reading
  // a write of 0 stores nothing; above 1 is refused with an exception
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cal_lo <= `ADRB_CAL_LO_DEF;
      o_cal_hi <= `ADRB_CAL_HI_DEF;
    end else if (i_req.wr && is_one(i_req.wdata)) begin
      if (i_req.addr == `ADRB_OFS_CAL_LO) begin
        o_cal_lo <= i_analog_raw;
      end
      if (i_req.addr == `ADRB_OFS_CAL_HI) begin
        o_cal_hi <= i_analog_raw;
      end
    end
  end

  // ========================================================================
  // stall timer: drive applied with zero speed for the whole window
  // it saturates, so the stall flag re-latches at once after a clear
  // while the drive is still stuck
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_drive.pwm_nonzero || i_drive.speed_rpm != 16'h0000) begin
      stall_cnt <= 25'd0;
    end else if (stall_cnt < 25'(`ADRB_STALL_CYC)) begin
      stall_cnt <= stall_cnt + 25'd1;
    end
  end

  // watchdog cause caught once after the reset is released
  // later changes of i_wd_reset are ignored until the next reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wd_seen <= 1'b0;
    end else begin
      wd_seen <= 1'b1;
    end
  end

  // ========================================================================
  // diagnostic flag word: latches set, live ones follow their cause
  // command-received and analog-initialized stay set until power-up reset
  always_comb begin
    next_flags = fault_flag_word;
    // latched causes; a completed reset drops those whose cause is gone
    if (rst_state == ADRB_RST_ACK) begin
      next_flags = next_flags & ~`ADRB_LATCH_MASK;
      next_flags[`ADRB_BIT_STALL]   = 1'b0;
      next_flags[`ADRB_BIT_OVSPD]   = 1'b0;
      next_flags[`ADRB_BIT_CALSPAN] = 1'b0;
      next_flags[`ADRB_BIT_SYSWD]   = 1'b0;
    end
    // set wins over the reset clear in the same cycle
    if (i_nv_fail)        next_flags[`ADRB_BIT_NVFAIL]  = 1'b1;
    if (i_nv_recovered)   next_flags[`ADRB_BIT_NVREC]   = 1'b1;
    if (i_speed_meas_bad) next_flags[`ADRB_BIT_SPDMEAS] = 1'b1;
    if (stall_cnt == 25'(`ADRB_STALL_CYC)) begin
      next_flags[`ADRB_BIT_STALL] = 1'b1;
    end
    if (!wd_seen && i_wd_reset) next_flags[`ADRB_BIT_SYSWD] = 1'b1;
    if (overspeed) next_flags[`ADRB_BIT_OVSPD] = 1'b1;
    if (i_drive.travel_done && i_span_short) begin
      next_flags[`ADRB_BIT_CALSPAN] = 1'b1;
    end
    // live flags, then the sticky command-received and analog-initialized bits
    next_flags[`ADRB_BIT_COMMTO]  = i_comm_lost && !i_src_local;
    next_flags[`ADRB_BIT_SHUTMOV] = i_shut_moving;
    next_flags[`ADRB_BIT_CALIB]   = i_calibrated;
    next_flags[`ADRB_BIT_LOOPACT] = i_loop_active;
    next_flags[`ADRB_BIT_ALOW]    = alow;
    next_flags[`ADRB_BIT_COAST]   = coast;
    if (wr_demand) next_flags[`ADRB_BIT_CMDRX] = 1'b1;
    if (ain_ok)    next_flags[`ADRB_BIT_AINIT] = 1'b1;
    next_flags[`ADRB_BIT_STARTDLY] = !i_start_done;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fault_flag_word <= 16'h0001;
    end else begin
      fault_flag_word <= next_flags;
    end
  end

  // ========================================================================
  // applied demand: source select, on/off resolve, loss defaults
  // the demand register keeps the written value; the loop and the applied
  // word both see the resolved on/off position
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_applied_pct <= 7'd0;
    end else if (!i_src_local) begin
      if (fault_flag_word[`ADRB_BIT_COMMTO]) begin
        o_applied_pct <= i_default_pct;
      end else if (i_onoff) begin
        o_applied_pct <= resolve_onoff(position_demand);
      end else begin
        o_applied_pct <= position_demand[6:0];
      end
    end else if (alow) begin
      o_applied_pct <= i_default_pct;
    end else begin
      o_applied_pct <= 7'd0;
    end
  end

  // actuation only after startup, with the source initialized, no fault
  // the comms timeout blocks too, but clears itself when the link returns
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_actuate_en <= 1'b0;
    end else begin
      o_actuate_en <= !fault_any && i_start_done
        && (i_src_local ? fault_flag_word[`ADRB_BIT_AINIT]
                        : fault_flag_word[`ADRB_BIT_CMDRX]);
    end
  end

  // ========================================================================
  // counters
  // both wrap at 32 bits; a host sees a roll-over as a small count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      actuation_counter <= 32'h0000_0000;
    end else if (i_drive.travel_done) begin
      actuation_counter <= actuation_counter + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      powered_time_counter <= 32'h0000_0000;
    end else if (i_minute_tick) begin
      powered_time_counter <= powered_time_counter + 32'h0000_0001;
    end
  end

  // low-half read snaps the upper half so a paired read is coherent
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      time_hi_snap <= 16'h0000;
      act_hi_snap  <= 16'h0000;
    end else if (i_req.rd) begin
      if (i_req.addr == `ADRB_OFS_TIME_LO) begin
        time_hi_snap <= powered_time_counter[31:16];
      end
      if (i_req.addr == `ADRB_OFS_ACT_LO) begin
        act_hi_snap <= actuation_counter[31:16];
      end
    end
  end

  // ========================================================================
  // read data and exception answer, one cycle after the strobe
  // writes to read-only or reserved words are dropped with no exception
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata     <= 16'h0000;
      o_exception <= 1'b0;
    end else begin
      o_exception <= i_req.wr && (
        (i_req.addr == `ADRB_OFS_DEMAND && !demand_ok) ||
        ((i_req.addr == `ADRB_OFS_CAL_LO || i_req.addr == `ADRB_OFS_CAL_HI)
         && i_req.wdata > 16'h0001));
      if (i_req.rd) begin
        unique case (i_req.addr)
          `ADRB_OFS_DEMAND:   o_rdata <= position_demand;
          `ADRB_OFS_FRESET:   o_rdata <= fault_reset_request;
          `ADRB_OFS_RECAL:    o_rdata <= recalibrate_request;
          `ADRB_OFS_TEST:     o_rdata <= `ADRB_TEST_PATTERN;
          `ADRB_OFS_POSITION: o_rdata <= i_calibrated
                                ? {9'd0, i_position_pct} : 16'h0000;
          `ADRB_OFS_APPLIED:  o_rdata <= {9'd0, o_applied_pct};
          `ADRB_OFS_FLAGS:    o_rdata <= fault_flag_word;
          `ADRB_OFS_ACT_LO:   o_rdata <= actuation_counter[15:0];
          `ADRB_OFS_ACT_HI:   o_rdata <= act_hi_snap;
          `ADRB_OFS_TIME_LO:  o_rdata <= powered_time_counter[15:0];
          `ADRB_OFS_TIME_HI:  o_rdata <= time_hi_snap;
          default:            o_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : adrb_bank

// ---- adrb_bank_monitor.sv ----
`timescale 1ns/1ns
`include "adrb_regs.svh"
// ==========================================================
// port checker for the holding-register bank
module adrb_bank_monitor
  import adrb_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_srst,
  // host port
  input wire adrb_req_t   i_req,
  input wire logic [15:0] o_rdata,
  input wire logic        o_exception,
  // calibration and loop side
  input wire logic [15:0] i_analog_raw,
  input wire logic        i_calibrated,
  input wire logic        o_recal_start,
  input wire logic [15:0] o_cal_lo,
  input wire logic [15:0] o_cal_hi,
  input wire logic        o_fault_ack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ========================================================
  // decode of the request in flight
  logic wr_dem, wr_lo, wr_hi, rd_any;
  assign wr_dem = i_req.wr && i_req.addr == `ADRB_OFS_DEMAND;
  assign wr_lo  = i_req.wr && i_req.addr == `ADRB_OFS_CAL_LO;
  assign wr_hi  = i_req.wr && i_req.addr == `ADRB_OFS_CAL_HI;
  assign rd_any = i_req.rd;

  // ========================================================
  // refusals and stores, answered one cycle after the strobe
  a_demand_refuse: assert property (
    wr_dem && i_req.wdata > `ADRB_FULL_PCT |=> o_exception)
    else $error("demand above full scale not refused");
  a_demand_accept: assert property (
    wr_dem && i_req.wdata <= `ADRB_FULL_PCT |=> !o_exception)
    else $error("legal demand refused");
  a_cal_refuse: assert property (
    (wr_lo || wr_hi) && i_req.wdata > 16'h0001
    |=> o_exception && $stable(o_cal_lo) && $stable(o_cal_hi))
    else $error("bad calibration write not refused");
  a_cal_lo_store: assert property (
    wr_lo && i_req.wdata == 16'h0001 |=> o_cal_lo == $past(i_analog_raw))
    else $error("zero point not stored");
  a_cal_hi_store: assert property (
    wr_hi && i_req.wdata == 16'h0001 |=> o_cal_hi == $past(i_analog_raw))
    else $error("full scale not stored");

  // readback of fixed and gated words
  a_test_read: assert property (
    rd_any && i_req.addr == `ADRB_OFS_TEST |=> o_rdata == `ADRB_TEST_PATTERN)
    else $error("test pattern wrong");
  a_rsvd_read: assert property (
    rd_any && i_req.addr > `ADRB_OFS_CAL_HI
    && i_req.addr <= `ADRB_OFS_RSVD_LAST |=> o_rdata == 16'h0000)
    else $error("reserved word not zero");
  a_pos_uncal: assert property (
    rd_any && i_req.addr == `ADRB_OFS_POSITION && !i_calibrated
    |=> o_rdata == 16'h0000)
    else $error("position shown while uncalibrated");

  // command pulses
  a_ack_single: assert property (
    $rose(o_fault_ack) |=> !o_fault_ack)
    else $error("fault ack longer than one cycle");
  a_recal_cmd: assert property (
    i_req.wr && i_req.addr == `ADRB_OFS_RECAL && i_req.wdata == 16'h0001
    |=> o_recal_start)
    else $error("recalibrate write gave no start pulse");

  // main scenarios reached
  c_refused: cover property (o_exception);
  c_ack: cover property (o_fault_ack);
  c_recal: cover property (o_recal_start);
endmodule : adrb_bank_monitor

bind adrb_bank adrb_bank_monitor adrb_bank_monitor_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata),
  .o_exception(o_exception), .i_analog_raw(i_analog_raw),
  .i_calibrated(i_calibrated), .o_recal_start(o_recal_start),
  .o_cal_lo(o_cal_lo), .o_cal_hi(o_cal_hi), .o_fault_ack(o_fault_ack));

// ---- adrb_bank_tb_top.sv ----
`timescale 1ns/1ns
`include "adrb_regs.svh"
// ==========================================================
// bench top: reset, directed register sequences, verdict
module adrb_bank_tb_top
  import adrb_pkg::*;
;
  // design-facing signals
  logic        i_clk = 1'h0;
  logic        i_srst = 1'h1;
  adrb_req_t   i_req;
  logic [15:0] o_rdata, o_cal_lo, o_cal_hi;
  logic        o_exception, o_actuate_en, o_recal_start, o_fault_ack;
  adrb_drive_t i_drive = '0;
  logic [15:0] i_analog_ua = 16'h03E8;
  logic [15:0] i_analog_raw = 16'h0000;
  logic [6:0]  i_position_pct = 7'h25, i_default_pct = 7'h19, o_applied_pct;
  logic        i_calibrated = 1'h0, i_span_short = 1'h0, i_comm_lost = 1'h0;
  logic        i_wd_reset = 1'h1, i_start_done = 1'h0, i_minute_tick = 1'h0;
  logic        i_src_local = 1'h0, i_onoff = 1'h0;
  // status inputs held quiet, except one pulse of nv-recovered, speed-meas-bad and shut-moving near the end
  logic        i_nv_fail = 1'h0, i_nv_recovered = 1'h0, i_shut_moving = 1'h0;
  logic        i_speed_meas_bad = 1'h0, i_loop_active = 1'h0;
  int          failures = 0, checks = 0;
  logic [16:0] q;
  logic [31:0] w;
  logic [6:0]  dv [5] = '{7'h31, 7'h32, 7'h64, 7'h00, 7'h49};
  logic [6:0]  ov [5] = '{7'h00, 7'h64, 7'h64, 7'h00, 7'h49};
  logic [4:0]  md = 5'h0F;

  adrb_bank adrb_bank_inst (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
    .o_rdata(o_rdata), .o_exception(o_exception), .i_drive(i_drive),
    .i_analog_ua(i_analog_ua), .i_analog_raw(i_analog_raw),
    .i_position_pct(i_position_pct), .i_calibrated(i_calibrated),
    .i_span_short(i_span_short), .i_comm_lost(i_comm_lost),
    .i_wd_reset(i_wd_reset), .i_nv_fail(i_nv_fail),
    .i_nv_recovered(i_nv_recovered), .i_speed_meas_bad(i_speed_meas_bad),
    .i_shut_moving(i_shut_moving), .i_loop_active(i_loop_active),
    .i_start_done(i_start_done), .i_minute_tick(i_minute_tick),
    .i_src_local(i_src_local), .i_onoff(i_onoff),
    .i_default_pct(i_default_pct), .o_applied_pct(o_applied_pct),
    .o_actuate_en(o_actuate_en), .o_recal_start(o_recal_start),
    .o_cal_lo(o_cal_lo), .o_cal_hi(o_cal_hi), .o_fault_ack(o_fault_ack));
  adrb_host adrb_host_inst (.i_clk(i_clk), .o_req(i_req),
    .i_rdata(o_rdata), .i_exception(o_exception));

  // 25 MHz clock
  always #20 i_clk = ~i_clk;

  // ========================================================
  // compare and count; case equality so unknowns never match
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    adrb_host_inst.xfer(1'h1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [15:0] a,
                     input logic [15:0] e);
    adrb_host_inst.xfer(1'h0, a, 16'h0000, q);
    chk(n, {16'h0000, e}, {16'h0000, q[15:0]});
  endtask : rdc
  // flag word under a mask
  task automatic fl(input logic [15:0] m, input logic [15:0] e);
    adrb_host_inst.xfer(1'h0, `ADRB_OFS_FLAGS, 16'h0000, q);
    chk("flags", {16'h0000, e}, {16'h0000, q[15:0] & m});
  endtask : fl
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    summarize();
  end

  // ========================================================
  // directed sequence
  initial begin
    repeat (16) @(negedge i_clk);
    i_srst = 1'h0;
    @(negedge i_clk);
    i_wd_reset = 1'h0;
    chk("cal_lo", 32'h0000_0FA0, {16'h0000, o_cal_lo});
    chk("cal_hi", 32'h0000_4E20, {16'h0000, o_cal_hi});
    fl(16'h1013, 16'h1011);
    rdc("test", `ADRB_OFS_TEST, `ADRB_TEST_PATTERN);
    for (int a = 5; a < 8; a++) begin
      rdc("reserved", a[15:0], 16'h0000);
    end
    rdc("position", `ADRB_OFS_POSITION, 16'h0000);
    i_calibrated = 1'h1;
    rdc("position", `ADRB_OFS_POSITION, 16'h0025);
    // calibration signal sequence during start delay
    wr(`ADRB_OFS_DEMAND, 16'h0064);
    wr(`ADRB_OFS_DEMAND, 16'h0000);
    chk("recal", 32'h1, {31'h0, o_recal_start});
    fl(16'h0004, 16'h0004);
    i_start_done = 1'h1;
    fl(16'h0001, 16'h0000);
    wr(`ADRB_OFS_RECAL, 16'h0001);
    chk("recal", 32'h1, {31'h0, o_recal_start});
    // watchdog fault cleared by a fault reset
    wr(`ADRB_OFS_FRESET, 16'h0001);
    chk("ack", 32'h1, {31'h0, o_fault_ack});
    fl(16'h1000, 16'h0000);
    rdc("freset", `ADRB_OFS_FRESET, 16'h0000);
    chk("act_en", 32'h1, {31'h0, o_actuate_en});
    wr(`ADRB_OFS_FRESET, 16'h0001);
    chk("ack", 32'h0, {31'h0, o_fault_ack});
    // demand range and on/off resolution; 100 then 0 after start delay
    wr(`ADRB_OFS_DEMAND, 16'h0065);
    chk("exc", 32'h1, {31'h0, q[16]});
    for (int k = 0; k < 5; k++) begin
      i_onoff = md[k];
      wr(`ADRB_OFS_DEMAND, {9'h000, dv[k]});
      chk("recal", 32'h0, {31'h0, o_recal_start});
      chk("exc", 32'h0, {31'h0, q[16]});
      rdc("applied", `ADRB_OFS_APPLIED, {9'h000, ov[k]});
      chk("applied_pct", {25'h0, ov[k]}, {25'h0, o_applied_pct});
    end
    // local source ignores the serial demand
    i_src_local = 1'h1;
    i_analog_ua = 16'h2710;
    rdc("applied", `ADRB_OFS_APPLIED, 16'h0000);
    i_analog_ua = 16'h07D0;
    fl(16'h0012, 16'h0012);
    rdc("applied", `ADRB_OFS_APPLIED, 16'h0019);
    i_analog_ua = 16'h2710;
    fl(16'h0010, 16'h0000);
    i_src_local = 1'h0;
    // link loss under serial source
    i_comm_lost = 1'h1;
    fl(16'h0100, 16'h0100);
    rdc("applied", `ADRB_OFS_APPLIED, 16'h0019);
    i_comm_lost = 1'h0;
    fl(16'h0100, 16'h0000);
    // analog calibration points, host applies the input first
    i_analog_raw = 16'h1234;
    wr(`ADRB_OFS_CAL_LO, 16'h0001);
    chk("cal_lo", 32'h0000_1234, {16'h0000, o_cal_lo});
    wr(`ADRB_OFS_CAL_LO, 16'h0002);
    chk("exc", 32'h1, {31'h0, q[16]});
    i_analog_raw = 16'h4321;
    wr(`ADRB_OFS_CAL_HI, 16'h0001);
    wr(`ADRB_OFS_CAL_HI, 16'h0005);
    chk("exc", 32'h1, {31'h0, q[16]});
    chk("cal_hi", 32'h0000_4321, {16'h0000, o_cal_hi});
    // coast follows speed, overspeed latches
    i_drive.speed_rpm = 16'h0A28;
    fl(16'h0808, 16'h0008);
    i_drive.speed_rpm = 16'h0000;
    fl(16'h0808, 16'h0000);
    i_drive.speed_rpm = 16'h0D48;
    @(negedge i_clk);
    i_drive.speed_rpm = 16'h0000;
    fl(16'h0808, 16'h0800);
    chk("act_en", 32'h0, {31'h0, o_actuate_en});
    wr(`ADRB_OFS_FRESET, 16'h0001);
    fl(16'h0800, 16'h0000);
    // two travels, both reporting a short span
    repeat (2) begin
      @(negedge i_clk);
      i_drive.travel_done = 1'h1;
      i_span_short = 1'h1;
      @(negedge i_clk);
      i_drive.travel_done = 1'h0;
    end
    i_span_short = 1'h0;
    adrb_host_inst.rd2(`ADRB_OFS_ACT_LO, w);
    chk("actuations", 32'h0000_0002, w);
    fl(16'h0400, 16'h0400);
    // powered time, both halves in one burst
    repeat (3) begin
      @(negedge i_clk);
      i_minute_tick = 1'h1;
      @(negedge i_clk);
      i_minute_tick = 1'h0;
    end
    adrb_host_inst.rd2(`ADRB_OFS_TIME_LO, w);
    chk("powered", 32'h0000_0003, w);
    // one-cycle causes latch in the upper bits, the live bit follows
    i_nv_recovered = 1'h1;
    i_speed_meas_bad = 1'h1;
    i_shut_moving = 1'h1;
    @(negedge i_clk);
    i_nv_recovered = 1'h0;
    i_speed_meas_bad = 1'h0;
    fl(16'h2280, 16'h2280);
    i_shut_moving = 1'h0;
    wr(`ADRB_OFS_FRESET, 16'h0001);
    fl(16'h2680, 16'h0000);
    summarize();
  end
endmodule : adrb_bank_tb_top

// ---- adrb_host.sv ----
`timescale 1ns/1ns
// ==========================================================
// serial master model driving the holding-register port
module adrb_host
  import adrb_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // register port, master side
  output adrb_req_t        o_req,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_exception
);
  // idle port: no strobe; stale fields inverted so they never match
  initial o_req = '0;

  // one request, answer taken at the next falling edge
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d, output logic [16:0] q);
    @(negedge i_clk);
    o_req = {w, ~w, a, d};
    @(negedge i_clk);
    q = {i_exception, i_rdata};
    o_req = {2'h0, ~a, ~d};
  endtask : xfer

  // both counter halves in one burst, low word first
  task automatic rd2(input logic [15:0] a, output logic [31:0] q);
    @(negedge i_clk);
    o_req = {2'h1, a, 16'h0000};
    @(negedge i_clk);
    q[15:0] = i_rdata;
    o_req = {2'h1, a + 16'h0001, 16'h0000};
    @(negedge i_clk);
    q[31:16] = i_rdata;
    o_req = {2'h0, ~a, 16'hFFFF};
  endtask : rd2
endmodule : adrb_host

// ---- adrb_pkg.sv ----
package adrb_pkg;

  // ========================================================================
  // host access on the holding-register port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } adrb_req_t;

  // drive measurements from the motor loop
  typedef struct packed {
    logic [15:0] speed_rpm;
    logic        pwm_nonzero;
    logic        travel_done;
  } adrb_drive_t;

  // reset sequencer states, gray along the path
  typedef enum logic [1:0] {
    ADRB_RST_IDLE = 2'b00,
    ADRB_RST_ACK  = 2'b01,
    ADRB_RST_DONE = 2'b11
  } adrb_rst_t;

  // recalibration by demand sequence
  typedef enum logic [1:0] {
    ADRB_SEQ_WAIT = 2'b00,
    ADRB_SEQ_FULL = 2'b01,
    ADRB_SEQ_HIT  = 2'b11
  } adrb_seq_t;

endpackage : adrb_pkg

// ---- adrb_regs.svh ----
`ifndef ADRB_REGS_SVH
`define ADRB_REGS_SVH

// ==========================================================================
// register offsets (word addresses on the holding-register port)
`define ADRB_OFS_DEMAND     16'h0000
`define ADRB_OFS_FRESET     16'h0001
`define ADRB_OFS_RECAL      16'h0002
`define ADRB_OFS_CAL_LO     16'h0003
`define ADRB_OFS_CAL_HI     16'h0004
`define ADRB_OFS_RSVD_LAST  16'h0007
`define ADRB_OFS_TEST       16'h0008
`define ADRB_OFS_POSITION   16'h0009
`define ADRB_OFS_APPLIED    16'h000A
`define ADRB_OFS_FLAGS      16'h000B
`define ADRB_OFS_ACT_LO     16'h000C
`define ADRB_OFS_ACT_HI     16'h000D
`define ADRB_OFS_TIME_LO    16'h000E
`define ADRB_OFS_TIME_HI    16'h000F

// ==========================================================================
// diagnostic flag bit positions
`define ADRB_BIT_NVFAIL     15
`define ADRB_BIT_STALL      14
`define ADRB_BIT_SPDMEAS    13
`define ADRB_BIT_SYSWD      12
`define ADRB_BIT_OVSPD      11
`define ADRB_BIT_CALSPAN    10
`define ADRB_BIT_NVREC      9
`define ADRB_BIT_COMMTO     8
`define ADRB_BIT_SHUTMOV    7
`define ADRB_BIT_CALIB      6
`define ADRB_BIT_LOOPACT    5
`define ADRB_BIT_ALOW       4
`define ADRB_BIT_COAST      3
`define ADRB_BIT_CMDRX      2
`define ADRB_BIT_AINIT      1
`define ADRB_BIT_STARTDLY   0
`define ADRB_LATCH_MASK     16'hFE00

// ==========================================================================
// reset values and thresholds
`define ADRB_TEST_PATTERN   16'hB38C
`define ADRB_OVSPD_RPM      16'h0CE4
`define ADRB_COAST_RPM      16'h09C4
`define ADRB_ALOW_UA        16'h0BB8
`define ADRB_AHIGH_UA       16'h4E20
`define ADRB_ONOFF_SPLIT    16'h0032
`define ADRB_FULL_PCT       16'h0064
`define ADRB_CAL_LO_DEF     16'h0FA0
`define ADRB_CAL_HI_DEF     16'h4E20

// ==========================================================================
// timing: stall window and its cycle count at the system clock
`define ADRB_STALL_MS       400
`define ADRB_CLK_HZ         25000000
`define ADRB_STALL_CYC      ((`ADRB_STALL_MS * (`ADRB_CLK_HZ / 1000)))

`endif
